// ### hw/flu_pkg.sv
package flu_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_SEL_W = 5;
    localparam int NUM_REGS = 32;

    // register offsets (byte addresses)
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_CR0 = 8'h04;
    localparam logic [7:0] OFF_XER = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_EXEC_CNT = 8'h10;
    localparam logic [7:0] OFF_GR_BASE = 8'h80;

    // opcodes
    localparam logic [5:0] OPC_EXT = 6'h1F;
    localparam logic [5:0] OPC_OR_IMM = 6'h18;
    localparam logic [9:0] XO_NOR = 10'h07C;
    localparam logic [9:0] XO_OR = 10'h1BC;
    localparam logic [9:0] XO_OR_COMPL = 10'h19C;

    // instruction field positions (bit 0 of the word is its lsb)
    localparam int POS_OPC = 26;
    localparam int POS_SRC = 21;
    localparam int POS_DST = 16;
    localparam int POS_SRC2 = 11;
    localparam int POS_XO = 1;
    localparam int POS_REC = 0;

    // condition field 0 bit positions
    localparam int CR_NEG = 3;
    localparam int CR_POS = 2;
    localparam int CR_ZERO = 1;
    localparam int CR_SO = 0;

    // exception register summary-overflow position
    localparam int XER_SO = 31;

    // status bit positions
    localparam int ST_ILLEGAL = 0;
    localparam int ST_DONE = 1;

    // reset values
    localparam logic [3:0] CR0_RST = 4'h0;
    localparam logic [31:0] XER_RST = 32'h00000000;
    localparam logic [31:0] WORD_RST = 32'h00000000;

    // operation kinds
    typedef enum logic [4:0] {
        FLU_OP_NONE = 5'b00001,
        FLU_OP_NOR = 5'b00010,
        FLU_OP_OR = 5'b00100,
        FLU_OP_OR_COMPL = 5'b01000,
        FLU_OP_OR_IMM = 5'b10000
    } flu_op_t;

    // decoded instruction
    typedef struct packed {
        flu_op_t op;
        logic [REG_SEL_W-1:0] source_reg_sel;
        logic [REG_SEL_W-1:0] dest_reg_sel;
        logic [REG_SEL_W-1:0] second_source_sel;
        logic [15:0] unsigned_immediate;
        logic record_flag;
    } flu_dec_t;

    // evaluator answer
    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic writes_cr0;
        logic legal;
    } flu_res_t;
endpackage

// ### hw/flu_logic_eval.sv
`timescale 1ns/100ps
module flu_logic_eval (
    input wire flu_pkg::flu_dec_t dec, // decoded instruction
    input wire logic [31:0] src_a, // first source operand
    input wire logic [31:0] src_b, // second source operand
    output flu_pkg::flu_res_t res // result and side effects
);
    // combinational evaluation of one logical operation
    always_comb begin
        res.value = flu_pkg::WORD_RST;
        res.writes_cr0 = 1'b0;
        res.legal = 1'b1;
        case (dec.op)
            flu_pkg::FLU_OP_NOR: begin // nor
                res.value = ~(src_a | src_b);
                res.writes_cr0 = dec.record_flag;
            end
            flu_pkg::FLU_OP_OR: begin // plain or
                res.value = src_a | src_b;
                res.writes_cr0 = dec.record_flag;
            end
            flu_pkg::FLU_OP_OR_COMPL: begin // or with complement
                res.value = src_a | ~src_b;
                res.writes_cr0 = dec.record_flag;
            end
            flu_pkg::FLU_OP_OR_IMM: begin // immediate, zero extended
                res.value = src_a | {16'h0000, dec.unsigned_immediate};
                res.writes_cr0 = 1'b0;
            end
            default: begin // not handled by this unit
                res.legal = 1'b0;
            end
        endcase
    end
endmodule

// ### hw/flu_top.sv
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module flu_top (
    input wire logic mclk, // core clock, 200 MHz
    input wire logic rst, // async reset, active high
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall, low on accept edge
    output logic exec_done // one-cycle pulse per executed word
);
    // general register storage
    logic [31:0] gr_q [0:flu_pkg::NUM_REGS-1];
    // condition field 0 and exception register
    logic [3:0] cr0_q;
    logic [31:0] xer_q;
    // sticky status and execution count
    logic illegal_q;
    logic [31:0] exec_cnt_q;
    logic [31:0] last_instr_q;
    // bus handshake state
    logic wait_q;
    logic [31:0] rdata_q;
    logic done_q;

    // request accepted at this edge
    logic acc_rd;
    logic acc_wr;
    // decoded address
    logic hit_instr;
    logic hit_cr0;
    logic hit_xer;
    logic hit_status;
    logic hit_cnt;
    logic hit_gr;
    logic [4:0] gr_idx;
    // byte-lane write mask
    logic [31:0] be_mask;
    // full-word write to the instruction register starts execution
    logic exec_go;
    // decoded instruction and operands
    flu_pkg::flu_dec_t dec;
    flu_pkg::flu_res_t res;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [3:0] cr0_new;
    logic [31:0] rd_mux;

    // accept happens on the edge where waitrequest is already low
    assign acc_rd = avs_read && !wait_q;
    assign acc_wr = avs_write && !wait_q;

    // address decode
    always_comb begin
        hit_instr = (avs_address == flu_pkg::OFF_INSTR);
        hit_cr0 = (avs_address == flu_pkg::OFF_CR0);
        hit_xer = (avs_address == flu_pkg::OFF_XER);
        hit_status = (avs_address == flu_pkg::OFF_STATUS);
        hit_cnt = (avs_address == flu_pkg::OFF_EXEC_CNT);
        hit_gr = (avs_address[7] == flu_pkg::OFF_GR_BASE[7]) && (avs_address[1:0] == 2'h0);
        gr_idx = avs_address[6:2];
    end

    // expand byte enables into a bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            be_mask[i*8 +: 8] = {8{avs_byteenable[i]}};
        end
    end

    // execution only on a full-word write
    assign exec_go = acc_wr && hit_instr && (avs_byteenable == 4'hF);

    // instruction field extraction
    always_comb begin
        dec.source_reg_sel = avs_writedata[flu_pkg::POS_SRC +: 5];
        dec.dest_reg_sel = avs_writedata[flu_pkg::POS_DST +: 5];
        dec.second_source_sel = avs_writedata[flu_pkg::POS_SRC2 +: 5];
        dec.unsigned_immediate = avs_writedata[15:0];
        dec.record_flag = avs_writedata[flu_pkg::POS_REC];
        dec.op = flu_pkg::FLU_OP_NONE;
        if (avs_writedata[flu_pkg::POS_OPC +: 6] == flu_pkg::OPC_OR_IMM) begin // immediate form
            dec.op = flu_pkg::FLU_OP_OR_IMM;
        end else if (avs_writedata[flu_pkg::POS_OPC +: 6] == flu_pkg::OPC_EXT) begin // register forms
            case (avs_writedata[flu_pkg::POS_XO +: 10])
                flu_pkg::XO_NOR: dec.op = flu_pkg::FLU_OP_NOR;
                flu_pkg::XO_OR: dec.op = flu_pkg::FLU_OP_OR;
                flu_pkg::XO_OR_COMPL: dec.op = flu_pkg::FLU_OP_OR_COMPL;
                default: dec.op = flu_pkg::FLU_OP_NONE; // other extended codes
            endcase
        end
    end

    // operand fetch from the register array
    assign src_a = gr_q[dec.source_reg_sel];
    assign src_b = gr_q[dec.second_source_sel];

    // logical evaluation
    flu_logic_eval u_eval (
        .dec(dec),
        .src_a(src_a),
        .src_b(src_b),
        .res(res)
    );

    // new field 0: signed compare with zero, summary overflow copied
    always_comb begin
        cr0_new[flu_pkg::CR_NEG] = res.value[31];
        cr0_new[flu_pkg::CR_POS] = !res.value[31] && (res.value != 32'h00000000);
        cr0_new[flu_pkg::CR_ZERO] = (res.value == 32'h00000000);
        cr0_new[flu_pkg::CR_SO] = xer_q[flu_pkg::XER_SO];
    end

    // read data selection
    always_comb begin
        rd_mux = flu_pkg::WORD_RST;
        if (hit_instr) begin // last full-word instruction write
            rd_mux = last_instr_q;
        end else if (hit_cr0) begin // condition field 0
            rd_mux = {28'h0000000, cr0_q};
        end else if (hit_xer) begin // exception register
            rd_mux = xer_q;
        end else if (hit_status) begin // sticky illegal, done
            rd_mux = {30'h00000000, done_q, illegal_q};
        end else if (hit_cnt) begin // executed word count
            rd_mux = exec_cnt_q;
        end else if (hit_gr) begin // general registers
            rd_mux = gr_q[gr_idx];
        end
    end

    // waitrequest: one stall cycle, then low for the accept edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else if ((avs_read || avs_write) && wait_q) begin // request seen
            wait_q <= 1'b0;
        end else begin // accepted or idle
            wait_q <= 1'b1;
        end
    end

    // read data, captured so it stands at the accept edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= flu_pkg::WORD_RST;
        end else if (avs_read && wait_q) begin // load before accept
            rdata_q <= rd_mux;
        end
    end

    // general register array: bus writes or execution result
    always_ff @(posedge mclk) begin
        if (exec_go && res.legal) begin // target register write
            gr_q[dec.dest_reg_sel] <= res.value;
        end else if (acc_wr && hit_gr) begin // software write
            gr_q[gr_idx] <= (gr_q[gr_idx] & ~be_mask) | (avs_writedata & be_mask);
        end
    end

    // condition field 0: record forms or software
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cr0_q <= flu_pkg::CR0_RST;
        end else if (exec_go && res.legal && res.writes_cr0) begin // record form only
            cr0_q <= cr0_new;
        end else if (acc_wr && hit_cr0 && avs_byteenable[0]) begin // software write
            cr0_q <= avs_writedata[3:0];
        end
    end

    // exception register: software only, execution never writes it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xer_q <= flu_pkg::XER_RST;
        end else if (acc_wr && hit_xer) begin // software write, ops leave it alone
            xer_q <= (xer_q & ~be_mask) | (avs_writedata & be_mask);
        end
    end

    // sticky illegal flag, set wins over write-one-to-clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            illegal_q <= 1'b0;
        end else if (exec_go && !res.legal) begin // unsupported word
            illegal_q <= 1'b1;
        end else if (acc_wr && hit_status && avs_byteenable[0] && avs_writedata[flu_pkg::ST_ILLEGAL]) begin
            illegal_q <= 1'b0;
        end
    end

    // execution bookkeeping
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            exec_cnt_q <= flu_pkg::WORD_RST;
            last_instr_q <= flu_pkg::WORD_RST;
            done_q <= 1'b0;
        end else begin
            done_q <= exec_go && res.legal;
            if (exec_go) begin // any full-word instruction write
                last_instr_q <= avs_writedata;
            end
            if (exec_go && res.legal) begin // count executed words
                exec_cnt_q <= exec_cnt_q + 32'h00000001;
            end
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign exec_done = done_q;
endmodule

// ### testbench/flu_checker.sv
`timescale 1ns/100ps
module flu_checker (
    input wire logic mclk, // core clock
    input wire logic rst, // async reset
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire logic exec_done // execute pulse
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic go; // accepted whole instruction write
    logic ext; // extended opcode group
    logic [9:0] xo; // extended opcode
    logic xr; // accepted exception register read
    logic xv_q; // exception value known
    logic [31:0] xs_q; // last exception value read
    assign go = avs_write && !avs_waitrequest && avs_address == flu_pkg::OFF_INSTR && avs_byteenable == 4'hF;
    assign ext = avs_writedata[31:26] == flu_pkg::OPC_EXT;
    assign xo = avs_writedata[10:1];
    assign xr = avs_read && !avs_waitrequest && avs_address == flu_pkg::OFF_XER;
    // track exception register, forget on software write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xv_q <= 1'b0;
            xs_q <= 32'h0;
        end else if (avs_write && !avs_waitrequest && avs_address == flu_pkg::OFF_XER) begin
            xv_q <= 1'b0;
        end else if (xr) begin
            xv_q <= 1'b1;
            xs_q <= avs_readdata;
        end
    end
    AST_NOR_EXEC: assert property (go && ext && xo == flu_pkg::XO_NOR |=> exec_done)
        else $error("nor not executed");
    AST_OR_EXEC: assert property (go && ext && xo == flu_pkg::XO_OR |=> exec_done)
        else $error("or not executed");
    AST_ORC_EXEC: assert property (go && ext && xo == flu_pkg::XO_OR_COMPL |=> exec_done)
        else $error("orc not executed");
    AST_ORI_EXEC: assert property (go && avs_writedata[31:26] == flu_pkg::OPC_OR_IMM |=> exec_done)
        else $error("ori not executed");
    AST_BAD_IDLE: assert property (go && ext && !(xo inside {10'h07C, 10'h1BC, 10'h19C}) |=> !exec_done)
        else $error("unsupported word executed");
    AST_DONE_CAUSE: assert property (exec_done |-> $past(go))
        else $error("done without instruction");
    AST_CR0_FIELD: assert property (avs_read && !avs_waitrequest && avs_address == 8'h04 |-> avs_readdata[31:4] == 28'h0)
        else $error("field 0 read wider than 4 bits");
    AST_XER_KEPT: assert property (xr && xv_q |-> avs_readdata == xs_q)
        else $error("exception register changed by execution");
    COV_NOR_REC: cover property (go && ext && xo == flu_pkg::XO_NOR && avs_writedata[0]);
    COV_ORI: cover property (go && !ext ##1 exec_done);
    COV_XER: cover property (xr && xv_q);
endmodule
bind flu_top flu_checker u_flu_checker (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .exec_done);

// ### testbench/flu_issue_model.sv
`timescale 1ns/100ps
module flu_issue_model (
    input wire logic mclk, // core clock
    input wire logic avs_waitrequest, // stall from unit
    output logic [7:0] avs_address, // byte address
    output logic avs_read, // read request
    output logic avs_write, // write request
    output logic [31:0] avs_writedata, // write data
    output logic [3:0] avs_byteenable // byte lanes
);
    // idle bus at time zero
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
    end
    // one transfer, held until accepted; released lines show inverse
    task automatic xfer(input logic rw, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= rw;
        avs_read <= !rw;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~d;
        @(posedge mclk);
    endtask
endmodule

// ### testbench/test_fixed_point_logical_ops.sv
`timescale 1ns/100ps
module test_fixed_point_logical_ops;
    logic mclk, rst, avs_read, avs_write, avs_waitrequest, exec_done; // bus controls
    logic [7:0] avs_address; // address
    logic [31:0] avs_writedata, avs_readdata; // data
    logic [3:0] avs_byteenable; // lanes
    logic [31:0] exp_q[$]; // expected reads
    int n_mismatch, compares, cyc; // counters
    int n_done; // executed-word pulses seen
    logic [31:0] ins[6] = '{32'h7C863B78, 32'h7C8638F9, 32'h7C863B38, 32'h7C863B79, 32'h60860079, 32'h7C863BB8};
    logic [31:0] res[6] = '{32'hF89A789B, 32'h07658764, 32'h9765B764, 32'hF89A789B, 32'h90003079, 32'h90003079};
    logic [3:0] crx[6] = '{4'h0, 4'h5, 4'h5, 4'h9, 4'h9, 4'h9}; // field 0 after each
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    flu_top u_flu_top (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .exec_done);
    flu_issue_model u_flu_issue_model (.mclk, .avs_waitrequest, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable);
    // compare one read word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_flu_issue_model.xfer(1'b1, a, d);
    endtask
    // note expectation, then read
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_flu_issue_model.xfer(1'b0, a, 32'h0);
    endtask
    function automatic logic [7:0] gra(input logic [4:0] n);
        return flu_pkg::OFF_GR_BASE + {1'b0, n, 2'b00};
    endfunction
    // read monitor: oldest note against accepted data
    always @(posedge mclk) begin
        if (exec_done === 1'b1) n_done++;
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) n_mismatch++;
            else chk(avs_readdata, exp_q.pop_front());
        end
    end
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        logic [4:0] s, t, d;
        logic [31:0] a, b, r, w;
        logic [15:0] imm;
        logic rc, so;
        int k;
        logic [3:0] cr;
        rst = 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        void'($urandom(32'h942e5185));
        // fixed operands, exception summary set
        wr(gra(5'd4), 32'h90003000);
        wr(gra(5'd7), 32'h789A789B);
        wr(flu_pkg::OFF_XER, 32'h80000000);
        for (int i = 0; i < 6; i++) begin
            wr(flu_pkg::OFF_INSTR, ins[i]);
            rd(gra(5'd6), res[i]);
            rd(flu_pkg::OFF_CR0, {28'h0, crx[i]});
            rd(flu_pkg::OFF_XER, 32'h80000000);
        end
        rd(8'h40, 32'h0);
        rd(flu_pkg::OFF_STATUS, 32'h00000001);
        rd(flu_pkg::OFF_EXEC_CNT, 32'h00000005);
        $display("test fixed_forms done");
        cr = 4'h9;
        // random operands, selects and forms
        for (int i = 0; i < 40; i++) begin
            k = $urandom % 4;
            s = 5'($urandom);
            t = s + 5'd1 + 5'($urandom % 31);
            d = 5'($urandom);
            a = $urandom;
            b = $urandom;
            imm = 16'($urandom);
            rc = 1'($urandom);
            so = 1'($urandom);
            r = k == 0 ? ~(a | b) : k == 1 ? (a | b) : k == 2 ? (a | ~b) : (a | {16'h0, imm});
            w = k == 3 ? {flu_pkg::OPC_OR_IMM, s, d, imm} : {flu_pkg::OPC_EXT, s, d, t,
                k == 0 ? flu_pkg::XO_NOR : k == 1 ? flu_pkg::XO_OR : flu_pkg::XO_OR_COMPL, rc};
            if (k < 3 && rc) cr = {$signed(r) < 0, $signed(r) > 0, r == 32'h0, so};
            wr(gra(s), a);
            wr(gra(t), b);
            wr(flu_pkg::OFF_XER, {so, 31'h0});
            wr(flu_pkg::OFF_INSTR, w);
            rd(gra(d), r);
            rd(flu_pkg::OFF_CR0, {28'h0, cr});
            rd(flu_pkg::OFF_XER, {so, 31'h0});
        end
        chk(32'(n_done), 32'h0000002D);
        $display("test random_forms done");
        final_report();
    end
endmodule
